// file: include/accel_route_defines.svh
`ifndef ACCEL_ROUTE_DEFINES_SVH
`define ACCEL_ROUTE_DEFINES_SVH

`define OFF_ENABLE_ONE     8'h17
`define OFF_ENABLE_TWO     8'h18
`define OFF_FIRST_ROUTE    8'h19
`define OFF_SHARED_ROUTE   8'h1A
`define OFF_SECOND_ROUTE   8'h1B
`define OFF_SAMPLE_SOURCE  8'h1E

`define RESET_VALUE        8'h00

`define MASK_ENABLE_ONE    8'h7F
`define MASK_ENABLE_TWO    8'h0F
`define MASK_MOTION_ROUTE  8'hFF
`define MASK_SHARED_ROUTE  8'hE7
`define MASK_SOURCE        8'h3F

`define BIT_EN_WATERMARK   6
`define BIT_EN_FULL        5
`define BIT_EN_READY       4
`define BIT_EN_LOWG        3
`define BIT_STILL_MODE     3

`define BIT_MOT_LEVEL      7
`define BIT_MOT_TILT       6
`define BIT_MOT_SINGLE     5
`define BIT_MOT_DOUBLE     4
`define BIT_MOT_STILL      3
`define BIT_MOT_ANYMOVE    2
`define BIT_MOT_HIGHG      1
`define BIT_MOT_LOWG       0

`endif

// file: include/accel_route_pkg.sv
`default_nettype none
package accel_route_pkg;

    typedef logic [7:0] byte_t;
    // Buffer events: bit 2 full, bit 1 watermark, bit 0 ready.
    typedef logic [2:0] buffer_evt_t;

    typedef struct packed {
        byte_t       enable_one;
        byte_t       enable_two;
        byte_t       first_route;
        byte_t       shared_route;
        byte_t       second_route;
        byte_t       sample_source;
        byte_t       latched_motion;
        buffer_evt_t latched_buffer;
        byte_t       read_data;
        logic        first_pin;
        logic        second_pin;
    } route_state_t;

endpackage
`default_nettype wire

// file: include/route_merge_if.sv
`timescale 1ns/1ps
`default_nettype none
interface route_merge_if;
    import accel_route_pkg::*;

    byte_t       motion_active;
    buffer_evt_t buffer_active;
    byte_t       first_route;
    byte_t       shared_route;
    byte_t       second_route;
    logic        first_hit;
    logic        second_hit;

    modport control (output motion_active, buffer_active, first_route, shared_route, second_route,
                     input first_hit, second_hit);
    modport merge   (input motion_active, buffer_active, first_route, shared_route, second_route,
                     output first_hit, second_hit);
endinterface
`default_nettype wire

// file: core/event_pin_merge.sv
`timescale 1ns/1ps
`default_nettype none
module event_pin_merge
(
    route_merge_if.merge rt
);
    import accel_route_pkg::*;

    function automatic logic route_hit(byte_t motion, byte_t motion_route, buffer_evt_t buffer,
                                       buffer_evt_t buffer_route);
        route_hit = (|(motion & motion_route)) | (|(buffer & buffer_route));
    endfunction

    // The shared register lists the second pin's buffer routes in reverse order, so they are swapped here.
    always_comb
    begin
        rt.first_hit  = route_hit(rt.motion_active, rt.first_route,
                                  rt.buffer_active, rt.shared_route[2:0]);
        rt.second_hit = route_hit(rt.motion_active, rt.second_route,
                                  rt.buffer_active,
                                  {rt.shared_route[5], rt.shared_route[6], rt.shared_route[7]});
    end
endmodule
`default_nettype wire

// file: core/accel_event_enable_route.sv
`timescale 1ns/1ps
`default_nettype none
`include "accel_route_defines.svh"
module accel_event_enable_route
(
    input  wire  logic                        core_clk,
    input  wire  logic                        srst,
    input  wire  logic                        reg_wr_en,
    input  wire  logic                        reg_rd_en,
    input  wire  logic [7:0]                  reg_addr,
    input  wire  accel_route_pkg::byte_t       reg_wdata,
    output logic       [7:0]                  reg_rdata,
    input  wire  accel_route_pkg::byte_t       group_zero_enable,
    input  wire  accel_route_pkg::byte_t       motion_event,
    input  wire  accel_route_pkg::buffer_evt_t buffer_event,
    input  wire  logic                        first_pin_polarity,
    input  wire  logic                        second_pin_polarity,
    input  wire  logic                        latch_enable,
    input  wire  logic                        clear_latched,
    output logic       [2:0]                  highg_axis_enable,
    output logic                              lowg_enable,
    output logic                              ready_enable,
    output logic                              full_enable,
    output logic                              watermark_enable,
    output logic       [2:0]                  stillness_axis_enable,
    output logic                              stillness_mode,
    output logic       [5:0]                  sample_source,
    output logic                              first_event_pin,
    output logic                              second_event_pin
);
    import accel_route_pkg::*;

    route_state_t st;
    route_state_t next_st;
    byte_t        motion_enabled;
    buffer_evt_t  buffer_enabled;
    byte_t        motion_now;
    buffer_evt_t  buffer_now;

    route_merge_if rt();

    event_pin_merge event_pin_merge_i
    (
        .rt (rt.merge)
    );

    // Grouped enables: an engine counts as on when any of its axis bits is set.
    always_comb
    begin
        motion_enabled = {group_zero_enable[7:4],
                          |st.enable_two[2:0],
                          |group_zero_enable[2:0],
                          |st.enable_one[2:0],
                          st.enable_one[`BIT_EN_LOWG]};
        buffer_enabled = {st.enable_one[`BIT_EN_FULL],
                          st.enable_one[`BIT_EN_WATERMARK],
                          st.enable_one[`BIT_EN_READY]};
        motion_now     = motion_event & motion_enabled;
        buffer_now     = buffer_event & buffer_enabled;
    end

    always_comb
    begin
        rt.motion_active = motion_now | st.latched_motion;
        rt.buffer_active = buffer_now | st.latched_buffer;
        rt.first_route   = st.first_route;
        rt.shared_route  = st.shared_route;
        rt.second_route  = st.second_route;
    end

    always_comb
    begin
        next_st = st;
        if (reg_wr_en)
        begin
            unique case (reg_addr)
                `OFF_ENABLE_ONE:    next_st.enable_one    = reg_wdata & `MASK_ENABLE_ONE;
                `OFF_ENABLE_TWO:    next_st.enable_two    = reg_wdata & `MASK_ENABLE_TWO;
                `OFF_FIRST_ROUTE:   next_st.first_route   = reg_wdata & `MASK_MOTION_ROUTE;
                `OFF_SHARED_ROUTE:  next_st.shared_route  = reg_wdata & `MASK_SHARED_ROUTE;
                `OFF_SECOND_ROUTE:  next_st.second_route  = reg_wdata & `MASK_MOTION_ROUTE;
                `OFF_SAMPLE_SOURCE: next_st.sample_source = reg_wdata & `MASK_SOURCE;
                default:            next_st.read_data     = st.read_data;
            endcase
        end
        if (reg_rd_en)
        begin
            unique case (reg_addr)
                `OFF_ENABLE_ONE:    next_st.read_data = st.enable_one;
                `OFF_ENABLE_TWO:    next_st.read_data = st.enable_two;
                `OFF_FIRST_ROUTE:   next_st.read_data = st.first_route;
                `OFF_SHARED_ROUTE:  next_st.read_data = st.shared_route;
                `OFF_SECOND_ROUTE:  next_st.read_data = st.second_route;
                `OFF_SAMPLE_SOURCE: next_st.read_data = st.sample_source;
                default:            next_st.read_data = `RESET_VALUE;
            endcase
        end
        // A new event in the clearing cycle survives the clear.
        if (latch_enable)
        begin
            next_st.latched_motion = (clear_latched ? `RESET_VALUE : st.latched_motion) | motion_now;
            next_st.latched_buffer = (clear_latched ? 3'h0 : st.latched_buffer) | buffer_now;
        end
        else
        begin
            next_st.latched_motion = `RESET_VALUE;
            next_st.latched_buffer = 3'h0;
        end
        next_st.first_pin  = rt.first_hit ? first_pin_polarity : ~first_pin_polarity;
        next_st.second_pin = rt.second_hit ? second_pin_polarity : ~second_pin_polarity;
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign reg_rdata             = st.read_data;
    assign highg_axis_enable     = st.enable_one[2:0];
    assign lowg_enable           = st.enable_one[`BIT_EN_LOWG];
    assign ready_enable          = st.enable_one[`BIT_EN_READY];
    assign full_enable           = st.enable_one[`BIT_EN_FULL];
    assign watermark_enable      = st.enable_one[`BIT_EN_WATERMARK];
    assign stillness_axis_enable = st.enable_two[2:0];
    assign stillness_mode        = st.enable_two[`BIT_STILL_MODE];
    assign sample_source         = st.sample_source[5:0];
    assign first_event_pin       = st.first_pin;
    assign second_event_pin      = st.second_pin;

    chk_enable_one_write: assert property (@(posedge core_clk) disable iff (srst)
        (reg_wr_en && reg_addr == `OFF_ENABLE_ONE) |=>
        ({watermark_enable, full_enable, ready_enable, lowg_enable, highg_axis_enable}
         == $past(reg_wdata[6:0])))
        else $error("Enable register one write did not reach the engine enables.");

    chk_still_mode_write: assert property (@(posedge core_clk) disable iff (srst)
        (reg_wr_en && reg_addr == `OFF_ENABLE_TWO) |=>
        (stillness_mode == $past(reg_wdata[3])) && (stillness_axis_enable == $past(reg_wdata[2:0])))
        else $error("Stillness mode or axis enables did not follow the write.");

    chk_source_write: assert property (@(posedge core_clk) disable iff (srst)
        (reg_wr_en && reg_addr == `OFF_SAMPLE_SOURCE) |=> (sample_source == $past(reg_wdata[5:0])))
        else $error("Sample source did not follow the write.");

    chk_reserved_read: assert property (@(posedge core_clk) disable iff (srst)
        (reg_rd_en && (reg_addr == 8'h1C || reg_addr == 8'h1D || reg_addr == 8'h1F)) |=> (reg_rdata == 8'h00))
        else $error("Reserved location did not read as zero.");

    chk_first_pin_level: assert property (@(posedge core_clk) disable iff (srst)
        (|(rt.motion_active & st.first_route)) |=> (first_event_pin == $past(first_pin_polarity)))
        else $error("First pin not at its active level after a routed event.");

    chk_second_pin_idle: assert property (@(posedge core_clk) disable iff (srst)
        !rt.second_hit ##1 !rt.second_hit |-> (second_event_pin == ~$past(second_pin_polarity)))
        else $error("Second pin active with no routed event.");

    chk_buffer_to_second: assert property (@(posedge core_clk) disable iff (srst)
        (rt.buffer_active[0] && st.shared_route[7]) |-> rt.second_hit)
        else $error("Ready event routed to the second pin did not hit it.");

    chk_clear_latched: assert property (@(posedge core_clk) disable iff (srst)
        (clear_latched && motion_now == 8'h00) |=> (st.latched_motion == 8'h00))
        else $error("Latched motion events survived a clear.");

    chk_latch_holds: assert property (@(posedge core_clk) disable iff (srst)
        (latch_enable && !clear_latched) |=> ((st.latched_motion & $past(st.latched_motion))
                                               == $past(st.latched_motion)))
        else $error("A latched event dropped without a clear.");

    chk_disabled_silent: assert property (@(posedge core_clk) disable iff (srst)
        (motion_enabled == 8'h00 && buffer_enabled == 3'h0 && st.latched_motion == 8'h00
         && st.latched_buffer == 3'h0) |-> (!rt.first_hit && !rt.second_hit))
        else $error("A disabled engine reached an event pin.");

    chk_first_route_write: assert property (@(posedge core_clk) disable iff (srst)
        (reg_wr_en && reg_addr == `OFF_FIRST_ROUTE) |=> (st.first_route == $past(reg_wdata)))
        else $error("First pin routing did not follow the write.");

    chk_second_route_write: assert property (@(posedge core_clk) disable iff (srst)
        (reg_wr_en && reg_addr == `OFF_SECOND_ROUTE) |=> (st.second_route == $past(reg_wdata)))
        else $error("Second pin routing did not follow the write.");

    chk_shared_route_mask: assert property (@(posedge core_clk) disable iff (srst)
        (reg_wr_en && reg_addr == `OFF_SHARED_ROUTE) |=> (st.shared_route == ($past(reg_wdata) & 8'hE7)))
        else $error("Shared routing did not keep its reserved bits at zero.");

    chk_ready_to_first: assert property (@(posedge core_clk) disable iff (srst)
        (rt.buffer_active[0] && st.shared_route[0]) |-> rt.first_hit)
        else $error("Ready event routed to the first pin did not hit it.");

    chk_full_to_second: assert property (@(posedge core_clk) disable iff (srst)
        (rt.buffer_active[2] && st.shared_route[5]) |-> rt.second_hit)
        else $error("Full event routed to the second pin did not hit it.");

    chk_second_pin_level: assert property (@(posedge core_clk) disable iff (srst)
        (|(rt.motion_active & st.second_route)) |=> (second_event_pin == $past(second_pin_polarity)))
        else $error("Second pin not at its active level after a routed event.");

    chk_lowg_gated: assert property (@(posedge core_clk) disable iff (srst)
        (st.enable_one[`BIT_EN_LOWG] == 1'b0) |-> (motion_now[0] == 1'b0))
        else $error("Low acceleration event passed while disabled.");

    chk_still_gated: assert property (@(posedge core_clk) disable iff (srst)
        (st.enable_two[2:0] == 3'h0) |-> (motion_now[3] == 1'b0))
        else $error("Stillness event passed with all its axes disabled.");

    chk_set_beats_clear: assert property (@(posedge core_clk) disable iff (srst)
        (latch_enable && clear_latched) |=> (st.latched_motion == $past(motion_now)))
        else $error("An event in the clearing cycle was lost.");

    chk_tap_source: assert property (@(posedge core_clk) disable iff (srst)
        (reg_wr_en && reg_addr == `OFF_SAMPLE_SOURCE) |=> (sample_source[5:4] == $past(reg_wdata[5:4])))
        else $error("New data or tap source did not follow the write.");

    chk_enable_one_read: assert property (@(posedge core_clk) disable iff (srst)
        (reg_rd_en && reg_addr == `OFF_ENABLE_ONE) |=> (reg_rdata == $past(st.enable_one)))
        else $error("Enable register one read back a wrong value.");
endmodule
`default_nettype wire

// file: dv/host_pin_watch.sv
`timescale 1ns/1ps
`default_nettype none
module host_pin_watch
(
    input  wire logic pin,
    input  wire logic polarity,
    output logic      active
);
    // The host reads a pin as asserted when it sits at the programmed active level.
    assign active = (pin === polarity);
endmodule
`default_nettype wire

// file: dv/accel_event_enable_route_tb.sv
`timescale 1ns/1ps
`default_nettype none
module accel_event_enable_route_tb;
    import accel_route_pkg::*;
    localparam logic [7:0] reg_addrs [6] = '{8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1E};
    localparam logic [7:0] reg_masks [6] = '{8'h7F, 8'h0F, 8'hFF, 8'hE7, 8'hFF, 8'h3F};
    logic        core_clk = 1'b0;
    logic        srst = 1'b1;
    logic        reg_wr_en = 1'b0;
    logic        reg_rd_en = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    byte_t       reg_wdata = 8'h00;
    byte_t       group_zero_enable = 8'h00;
    byte_t       motion_event = 8'h00;
    buffer_evt_t buffer_event = 3'h0;
    logic        pol1 = 1'b0;
    logic        pol2 = 1'b0;
    logic        latch_enable = 1'b0;
    logic        clear_latched = 1'b0;
    logic [7:0]  reg_rdata;
    logic [2:0]  highg_axis_enable, stillness_axis_enable;
    logic        lowg_enable, ready_enable, full_enable, watermark_enable, stillness_mode;
    logic [5:0]  sample_source;
    logic        first_event_pin, second_event_pin, first_active, second_active;
    int          error_cnt = 0;
    int          checks = 0;

    always #4 core_clk = ~core_clk;

    accel_event_enable_route accel_event_enable_route_i
    (
        .core_clk(core_clk), .srst(srst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .group_zero_enable(group_zero_enable), .motion_event(motion_event), .buffer_event(buffer_event),
        .first_pin_polarity(pol1), .second_pin_polarity(pol2), .latch_enable(latch_enable),
        .clear_latched(clear_latched), .highg_axis_enable(highg_axis_enable), .lowg_enable(lowg_enable),
        .ready_enable(ready_enable), .full_enable(full_enable), .watermark_enable(watermark_enable),
        .stillness_axis_enable(stillness_axis_enable), .stillness_mode(stillness_mode),
        .sample_source(sample_source), .first_event_pin(first_event_pin), .second_event_pin(second_event_pin)
    );
    host_pin_watch host_pin_watch_i (.pin(first_event_pin), .polarity(pol1), .active(first_active));
    host_pin_watch host_pin_watch_i2 (.pin(second_event_pin), .polarity(pol2), .active(second_active));

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input byte_t d);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd_en <= 1'b0;
        @(posedge core_clk);
        @(negedge core_clk);
        check(reg_rdata, exp, what);
        @(posedge core_clk);
    endtask

    task automatic pins(input logic e1, input logic e2, input string what);
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        check({7'h00, first_active}, {7'h00, e1}, what);
        check({7'h00, second_active}, {7'h00, e2}, what);
        @(posedge core_clk);
    endtask

    task automatic scn_registers();
        for (int i = 0; i < 6; i++) rd(reg_addrs[i], 8'h00, "reset value");
        for (int i = 0; i < 6; i++) wr(reg_addrs[i], 8'hFF);
        for (int i = 0; i < 6; i++) rd(reg_addrs[i], reg_masks[i], "masked readback");
        wr(8'h17, 8'h55);
        wr(8'h18, 8'h0A);
        wr(8'h1E, 8'h25);
        check({1'b0, watermark_enable, full_enable, ready_enable, lowg_enable, highg_axis_enable}, 8'h55, "en1");
        check({4'h0, stillness_mode, stillness_axis_enable}, 8'h0A, "en2");
        check({2'b00, sample_source}, 8'h25, "source");
        wr(8'h1C, 8'hA5);
        wr(8'h1D, 8'hA5);
        wr(8'h1F, 8'hA5);
        rd(8'h1C, 8'h00, "reserved 1C");
        rd(8'h1D, 8'h00, "reserved 1D");
        rd(8'h1F, 8'h00, "reserved 1F");
        rd(8'h17, 8'h55, "en1 kept");
    endtask

    task automatic scn_motion_routing();
        wr(8'h17, 8'h0F);
        wr(8'h18, 8'h07);
        group_zero_enable <= 8'hF7;
        for (int b = 0; b < 8; b++)
        begin
            for (int p = 0; p < 2; p++)
            begin
                wr(8'h19, (p == 0) ? 8'h01 << b : 8'h00);
                wr(8'h1B, (p == 1) ? 8'h01 << b : 8'h00);
                pol1 <= b[0];
                pol2 <= ~b[0];
                motion_event <= 8'h01 << b;
                pins(p == 0, p == 1, "motion route");
                motion_event <= 8'h00;
                pins(1'b0, 1'b0, "motion idle");
            end
        end
    endtask

    task automatic scn_disabled_and_buffer();
        wr(8'h17, 8'h00);
        wr(8'h18, 8'h00);
        group_zero_enable <= 8'h00;
        wr(8'h19, 8'hFF);
        wr(8'h1B, 8'hFF);
        wr(8'h1A, 8'hE7);
        motion_event <= 8'hFF;
        buffer_event <= 3'h7;
        pins(1'b0, 1'b0, "disabled engines");
        motion_event <= 8'h00;
        buffer_event <= 3'h0;
        wr(8'h17, 8'h70);
        for (int k = 0; k < 3; k++)
        begin
            wr(8'h1A, 8'h01 << k);
            buffer_event <= 3'h1 << k;
            pins(1'b1, 1'b0, "buffer first pin");
            wr(8'h1A, 8'h80 >> k);
            pins(1'b0, 1'b1, "buffer second pin");
            buffer_event <= 3'h0;
            pins(1'b0, 1'b0, "buffer idle");
        end
    endtask

    task automatic scn_latch();
        latch_enable <= 1'b1;
        wr(8'h17, 8'h08);
        wr(8'h19, 8'h01);
        wr(8'h1A, 8'h00);
        wr(8'h1B, 8'h00);
        motion_event <= 8'h01;
        @(posedge core_clk);
        motion_event <= 8'h00;
        pins(1'b1, 1'b0, "latched event");
        pins(1'b1, 1'b0, "latch kept");
        clear_latched <= 1'b1;
        @(posedge core_clk);
        clear_latched <= 1'b0;
        pins(1'b0, 1'b0, "latch cleared");
        motion_event <= 8'h01;
        clear_latched <= 1'b1;
        @(posedge core_clk);
        motion_event <= 8'h00;
        clear_latched <= 1'b0;
        pins(1'b1, 1'b0, "set beats clear");
        clear_latched <= 1'b1;
        @(posedge core_clk);
        clear_latched <= 1'b0;
        pins(1'b0, 1'b0, "cleared again");
        latch_enable <= 1'b0;
    endtask

    task automatic give_verdict();
        $display("Checks %0d, errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        scn_registers();
        scn_motion_routing();
        scn_disabled_and_buffer();
        scn_latch();
        give_verdict();
    end
endmodule
`default_nettype wire
